// file: rtl/abs_pos_pkg.sv
// Purpose: Shared constants and types of the absolute position tracker.
// Assumes: 200 MHz system clock.
// Notes:   Word addresses of the status table are 16-bit register indexes.
package abs_pos_pkg;

	// -------------------------------------------------------------------
	// Position format
	// -------------------------------------------------------------------
	localparam int          REV_W      = 16;
	localparam int          PULSE_W    = 17;
	localparam int          TOTAL_W    = 32;
	localparam int          PULSES_PER_REV = 131072;
	localparam logic [16:0] PULSE_MAX  = 17'h1FFFF;
	localparam logic [15:0] REV_MAX    = 16'h7FFF;
	localparam logic [15:0] REV_MIN    = 16'h8000;
	localparam logic [1:0]  QUAD_TOP   = 2'h3;
	localparam logic [1:0]  QUAD_BOT   = 2'h0;

	// -------------------------------------------------------------------
	// Communication status table
	// -------------------------------------------------------------------
	localparam int          ADDR_W           = 16;
	localparam int          DATA_W           = 16;
	localparam logic [15:0] ADDR_AFTER_GEAR  = 16'h0000;
	localparam logic [15:0] ADDR_BEFORE_GEAR = 16'h0024;
	localparam logic [15:0] ADDR_HI_OFS      = 16'h0001;
	localparam logic [15:0] COORD_INIT_VAL   = 16'h0001;
	localparam int          GEAR_W           = 16;
	localparam int          SHIFT_W          = 5;

	// -------------------------------------------------------------------
	// Overload timing
	// -------------------------------------------------------------------
	localparam int  CLK_HZ        = 200_000_000;
	localparam int  MS_PER_S      = 1000;
	localparam int  MS_CYCLES     = CLK_HZ / MS_PER_S;
	localparam real TRIP_SMALL_S  = 2.46;
	localparam real TRIP_MID_S    = 3.33;
	localparam real TRIP_80_S     = 5.51;
	localparam int  TRIP_SMALL_MS = int'($floor(TRIP_SMALL_S * MS_PER_S + 0.5));
	localparam int  TRIP_MID_MS   = int'($floor(TRIP_MID_S * MS_PER_S + 0.5));
	localparam int  TRIP_80_MS    = int'($floor(TRIP_80_S * MS_PER_S + 0.5));
	localparam int  MS_W          = 13;

	typedef enum logic [1:0] {FRAME_SMALL, FRAME_MID, FRAME_80} frame_t;

endpackage

// file: rtl/pos_track_if.sv
// Purpose: Carries the turn count and single-turn position between modules.
// Assumes: One clock domain.
// Notes:   The owner requests a new origin with a one-cycle rezero pulse.
`timescale 1ns/10ps
interface pos_track_if;
	logic signed [15:0] rev;
	logic [16:0]        pulse;
	logic               overflow;
	logic               rezero;

	modport counter (output rev, output pulse, output overflow, input rezero);
	modport owner   (input rev, input pulse, input overflow, output rezero);
endinterface

// file: rtl/revolution_counter.sv
// Purpose: Multi-turn revolution count from a 17-bit single-turn encoder.
// Assumes: The encoder moves less than a quarter turn between samples.
// Notes:   Overflow latches until a new origin; the count stops at its limit and counts back on reversal.
`timescale 1ns/10ps
module revolution_counter
	import abs_pos_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic [16:0]        enc_pulse,
	input  wire logic               enc_valid,
	pos_track_if.counter            pos
);
	logic [16:0]        offset_q;
	logic [16:0]        rel;
	logic signed [15:0] rev_q;
	logic [16:0]        pulse_q;
	logic               ovf_q;
	logic               wrap_up;
	logic               wrap_dn;
	logic               ovf_set;

	// Position relative to the origin wraps naturally at one turn.
	assign rel     = enc_pulse - offset_q;
	assign wrap_up = (pulse_q[16:15] == QUAD_TOP) && (rel[16:15] == QUAD_BOT);
	assign wrap_dn = (pulse_q[16:15] == QUAD_BOT) && (rel[16:15] == QUAD_TOP);
	// A limit crossing in the rezero cycle still latches, so no overflow is lost.
	assign ovf_set = enc_valid && ((wrap_up && rev_q == $signed(REV_MAX))
		|| (wrap_dn && rev_q == $signed(REV_MIN)));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			offset_q <= '0;
		end else if (pos.rezero) begin
			offset_q <= enc_pulse;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pulse_q <= '0;
		end else if (pos.rezero) begin
			pulse_q <= '0;
		end else if (enc_valid) begin
			pulse_q <= rel;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rev_q <= '0;
			ovf_q <= 1'b0;
		end else if (pos.rezero) begin
			rev_q <= '0;
			ovf_q <= ovf_set;
		end else if (enc_valid && wrap_up) begin
			if (rev_q == $signed(REV_MAX)) begin
				ovf_q <= 1'b1;
			end else begin
				rev_q <= rev_q + 16'sh0001;
			end
		end else if (enc_valid && wrap_dn) begin
			if (rev_q == $signed(REV_MIN)) begin
				ovf_q <= 1'b1;
			end else begin
				rev_q <= rev_q - 16'sh0001;
			end
		end
	end

	assign pos.rev      = rev_q;
	assign pos.pulse    = pulse_q;
	assign pos.overflow = ovf_q;
endmodule

// file: rtl/overload_timer.sv
// Purpose: Trips after continuous 300 percent load for a frame's time.
// Assumes: Load comparison is done outside and arrives as one level.
// Notes:   Dropping the load restarts the time; the trip holds until reset.
`timescale 1ns/10ps
module overload_timer
	import abs_pos_pkg::*;
#(
	parameter int MS_TICKS = MS_CYCLES
)(
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   load_over_300,
	input  wire frame_t frame,
	output logic        trip_q
);
	logic [17:0]     div_q;
	logic            tick;
	logic [MS_W-1:0] ms_q;

	function automatic logic [MS_W-1:0] trip_ms(input frame_t f);
		unique case (f)
			FRAME_SMALL: trip_ms = MS_W'(TRIP_SMALL_MS);
			FRAME_MID:   trip_ms = MS_W'(TRIP_MID_MS);
			FRAME_80:    trip_ms = MS_W'(TRIP_80_MS);
			default:     trip_ms = MS_W'(TRIP_SMALL_MS);
		endcase
	endfunction

	assign tick = (div_q == 18'(MS_TICKS - 1));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_q <= '0;
		end else if (!load_over_300 || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 18'h00001;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ms_q   <= '0;
			trip_q <= 1'b0;
		end else if (!load_over_300) begin
			ms_q <= '0;
		end else if (tick) begin
			ms_q <= ms_q + 13'h0001;
			if (ms_q + 13'h0001 >= trip_ms(frame)) begin
				trip_q <= 1'b1;
			end
		end
	end
endmodule

// file: rtl/absolute_position_tracker.sv
// Purpose: Absolute multi-turn position tracking and its alarms for a servo drive.
// Assumes: Reset stands for a power cycle; encoder and battery inputs are synchronous.
// Notes:   Status words are read through a one-word read port with word addresses.
//
// Notes on behaviour
// - Turn count limited -32768..32767, overflow alarms.
// - One turn is 131072 pulses, 17 bits.
// - Total equals turns times 131072 plus pulse for turns -16384..16383.
// - Absolute mode with incremental motor raises alarm.
// - Low backup battery raises battery low alarm.
// - Battery below 2.45 V loses stored position.
// - Absolute mode takes effect only after restart.
// - First absolute power-on raises battery loss alarm.
// - No valid origin at power-on: position lost.
// - Coordinate init write of 1 sets origin.
// - Program mode origin return resets coordinates.
// - Lost or overflowed position is invalid until homed.
// - Word 0x0000 holds gear-scaled feedback, two words.
// - Word 0x0024 holds unscaled feedback, two words.
// - Smallest frame trips after 2.46 s at 300%.
// - 80 mm frame trips after 5.51 s at 300%.
`timescale 1ns/10ps
module absolute_position_tracker
	import abs_pos_pkg::*;
#(
	parameter int MS_TICKS = abs_pos_pkg::MS_CYCLES
)(
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic [abs_pos_pkg::PULSE_W-1:0] enc_pulse,
	input  wire logic                           enc_valid,
	input  wire logic                           motor_is_absolute,
	input  wire logic                           absolute_system_enable_param,
	input  wire logic                           backup_data_invalid,
	input  wire logic                           origin_valid,
	input  wire logic                           battery_low,
	input  wire logic                           battery_below_min,
	input  wire logic                           coord_init_param_wr,
	input  wire logic [abs_pos_pkg::DATA_W-1:0]  coord_init_param,
	input  wire logic                           internal_position_program_mode,
	input  wire logic                           origin_return_done,
	input  wire logic                           load_over_300,
	input  wire abs_pos_pkg::frame_t            frame,
	input  wire logic [abs_pos_pkg::GEAR_W-1:0]  gear_num,
	input  wire logic [abs_pos_pkg::SHIFT_W-1:0] gear_shift,
	input  wire logic                           reg_rd,
	input  wire logic [abs_pos_pkg::ADDR_W-1:0]  reg_addr,
	output logic [abs_pos_pkg::DATA_W-1:0]       reg_rdata,
	output logic                                reg_rvalid,
	output logic                                reg_err,
	output logic                                abs_mode,
	output logic                                revolution_overflow_alarm,
	output logic                                wrong_motor_type_alarm,
	output logic                                battery_low_alarm,
	output logic                                encoder_battery_loss_alarm,
	output logic                                position_lost_alarm,
	output logic                                position_valid,
	output logic                                overload_trip
);
	import abs_pos_pkg::*;

	pos_track_if pos ();

	logic                      started_q;
	logic                      abs_mode_q;
	logic                      active;
	logic                      init_done_q;
	logic                      wrong_motor_q;
	logic                      batt_low_q;
	logic                      batt_loss_q;
	logic                      lost_q;
	logic                      rezero_q;
	logic                      origin_set;
	logic                      valid_q;
	logic signed [TOTAL_W-1:0] total_q;
	logic signed [TOTAL_W-1:0] geared_q;
	logic signed [47:0]        product;
	logic [DATA_W-1:0]         rdata_q;
	logic [DATA_W-1:0]         hi_snap_q;
	logic                      rvalid_q;
	logic                      err_q;

	// ---------------------------------------------------------------------
	// Position counting and overload timing
	// ---------------------------------------------------------------------
	revolution_counter u_count (
		.clk       (clk),
		.reset     (reset),
		.enc_pulse (enc_pulse),
		.enc_valid (enc_valid),
		.pos       (pos.counter)
	);

	overload_timer #(
		.MS_TICKS (MS_TICKS)
	) u_overload (
		.clk           (clk),
		.reset         (reset),
		.load_over_300 (load_over_300),
		.frame         (frame),
		.trip_q        (overload_trip)
	);

	// ---------------------------------------------------------------------
	// Start-up capture of the absolute mode setting
	// ---------------------------------------------------------------------
	// The parameter is only looked at once after reset release, so a write
	// while running changes nothing until the next restart.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			started_q  <= 1'b0;
			abs_mode_q <= 1'b0;
		end else if (!started_q) begin
			started_q  <= 1'b1;
			abs_mode_q <= absolute_system_enable_param;
		end
	end

	assign active = started_q && abs_mode_q;

	// ---------------------------------------------------------------------
	// Alarms
	// ---------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrong_motor_q <= 1'b0;
		end else if (active && !motor_is_absolute) begin
			wrong_motor_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			batt_low_q <= 1'b0;
		end else if (active && battery_low) begin
			batt_low_q <= 1'b1;
		end
	end

	// Loss of backup data is only cleared by a power cycle.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			batt_loss_q <= 1'b0;
		end else if (active && battery_below_min) begin
			batt_loss_q <= 1'b1;
		end else if (active && backup_data_invalid && !init_done_q) begin
			batt_loss_q <= 1'b1;
		end
	end

	assign origin_set = (coord_init_param_wr && coord_init_param == COORD_INIT_VAL)
		|| (internal_position_program_mode && origin_return_done);

	// A battery drop below minimum in the same cycle as an origin request wins, because the
	// encoder data behind that origin cannot be trusted.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lost_q <= 1'b0;
		end else if (active && battery_below_min) begin
			lost_q <= 1'b1;
		end else if (active && origin_set) begin
			lost_q <= 1'b0;
		end else if (active && !origin_valid && !init_done_q) begin
			lost_q <= 1'b1;
		end
	end

	// Marks that the power-on origin check has been made once.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			init_done_q <= 1'b0;
		end else if (active) begin
			init_done_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rezero_q <= 1'b0;
		end else begin
			rezero_q <= active && origin_set;
		end
	end

	assign pos.rezero = rezero_q;

	// ---------------------------------------------------------------------
	// Position value
	// ---------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= active && !lost_q && !pos.overflow && !batt_loss_q;
		end
	end

	// Turns outside -16384..16383 do not fit 32 bits and wrap; the
	// overflow alarm only guards the 16-bit turn range.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			total_q <= '0;
		end else begin
			total_q <= TOTAL_W'({pos.rev, pos.pulse});
		end
	end

	assign product = 48'(total_q) * $signed({1'b0, gear_num});

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			geared_q <= '0;
		end else begin
			geared_q <= TOTAL_W'(product >>> gear_shift);
		end
	end

	// ---------------------------------------------------------------------
	// Status table read port
	// ---------------------------------------------------------------------
	// Reading the low word freezes the high word of the same value so that
	// a two-word read is coherent; read low first.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_q   <= '0;
			hi_snap_q <= '0;
			rvalid_q  <= 1'b0;
			err_q     <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			err_q    <= 1'b0;
			if (reg_rd) begin
				unique case (reg_addr)
					ADDR_AFTER_GEAR: begin
						rdata_q   <= geared_q[15:0];
						hi_snap_q <= geared_q[31:16];
					end
					ADDR_AFTER_GEAR + ADDR_HI_OFS: begin
						rdata_q <= hi_snap_q;
					end
					ADDR_BEFORE_GEAR: begin
						rdata_q   <= total_q[15:0];
						hi_snap_q <= total_q[31:16];
					end
					ADDR_BEFORE_GEAR + ADDR_HI_OFS: begin
						rdata_q <= hi_snap_q;
					end
					default: begin
						rdata_q <= '0;
						err_q   <= 1'b1;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------------
	assign reg_rdata                  = rdata_q;
	assign reg_rvalid                 = rvalid_q;
	assign reg_err                    = err_q;
	assign abs_mode                   = abs_mode_q;
	assign revolution_overflow_alarm  = pos.overflow;
	assign wrong_motor_type_alarm     = wrong_motor_q;
	assign battery_low_alarm          = batt_low_q;
	assign encoder_battery_loss_alarm = batt_loss_q;
	assign position_lost_alarm        = lost_q;
	assign position_valid             = valid_q;
endmodule

// file: tb/host_reader.sv
// Purpose: Host side of the status word read port.
// Assumes: One read is in flight at a time.
// Notes:   The address is held after the strobe, so it never changes under a read.
`timescale 1ns/10ps
module host_reader (
	input  wire logic        clk,
	output logic             reg_rd,
	output logic [15:0]      reg_addr,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	input  wire logic        reg_err
);
	initial begin
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
	end

	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
		d = 16'hDEAD;
		e = 1'b0;
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		repeat (4) begin
			@(posedge clk);
			if (reg_rvalid === 1'b1) begin
				d = reg_rdata;
				e = reg_err;
				break;
			end
		end
	endtask

	// The low word is read first because that read snapshots the high word.
	task automatic rd32(input logic [15:0] base, output logic [31:0] v);
		logic [15:0] lo;
		logic [15:0] hi;
		logic        e;
		rd(base, lo, e);
		rd(base + 16'h0001, hi, e);
		v = {hi, lo};
	endtask
endmodule

// file: tb/abs_pos_monitor.sv
// Purpose: Port-level assertions of the absolute position tracker.
// Assumes: One clock domain; reset asynchronous, active high.
// Notes:   Overload time allows one tick of slack for a free-running prescaler.
`timescale 1ns/10ps
module abs_pos_monitor #(
	parameter int MS_TICKS = 4
)(
	input wire logic                clk,
	input wire logic                reset,
	input wire logic                motor_is_absolute,
	input wire logic                battery_low,
	input wire logic                battery_below_min,
	input wire logic                coord_init_param_wr,
	input wire logic [15:0]         coord_init_param,
	input wire logic                internal_position_program_mode,
	input wire logic                origin_return_done,
	input wire logic                load_over_300,
	input wire abs_pos_pkg::frame_t frame,
	input wire logic                reg_rd,
	input wire logic [15:0]         reg_addr,
	input wire logic [15:0]         reg_rdata,
	input wire logic                reg_rvalid,
	input wire logic                reg_err,
	input wire logic                abs_mode,
	input wire logic                revolution_overflow_alarm,
	input wire logic                wrong_motor_type_alarm,
	input wire logic                battery_low_alarm,
	input wire logic                encoder_battery_loss_alarm,
	input wire logic                position_lost_alarm,
	input wire logic                position_valid,
	input wire logic                overload_trip
);
	import abs_pos_pkg::*;
	logic mapped;
	logic started_q;
	int   cnt_q;
	int   lim;
	assign mapped = reg_addr == ADDR_AFTER_GEAR || reg_addr == ADDR_AFTER_GEAR + ADDR_HI_OFS
		|| reg_addr == ADDR_BEFORE_GEAR || reg_addr == ADDR_BEFORE_GEAR + ADDR_HI_OFS;
	assign lim = MS_TICKS * (frame == FRAME_SMALL ? TRIP_SMALL_MS
		: frame == FRAME_MID ? TRIP_MID_MS : TRIP_80_MS);
	// Mode is captured on the first edge, so its steadiness is judged from the second.
	always_ff @(posedge clk or posedge reset)
		if (reset)
			started_q <= 1'b0;
		else
			started_q <= 1'b1;
	always_ff @(posedge clk or posedge reset)
		if (reset)
			cnt_q <= 0;
		else
			cnt_q <= load_over_300 ? cnt_q + 1 : 0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rd_only; !reg_rd |=> !reg_rvalid; endproperty
	a_rd_only: assert property (p_rd_only) else $error("answer without read");
	property p_unmapped; reg_rd && !mapped |=> reg_err && reg_rdata == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_mapped; reg_rd && mapped |=> !reg_err; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped read refused");
	property p_coord;
		abs_mode && coord_init_param_wr && coord_init_param == COORD_INIT_VAL
			&& !battery_below_min |=> !position_lost_alarm;
	endproperty
	a_coord: assert property (p_coord) else $error("init left position lost");
	property p_prog;
		abs_mode && internal_position_program_mode && origin_return_done
			&& !battery_below_min |=> !position_lost_alarm;
	endproperty
	a_prog: assert property (p_prog) else $error("origin return ignored");
	sequence s_lost; encoder_battery_loss_alarm && position_lost_alarm; endsequence
	property p_below; abs_mode && battery_below_min |-> ##[1:2] s_lost; endproperty
	a_below: assert property (p_below) else $error("battery loss not raised");
	property p_low; abs_mode && battery_low |-> ##[1:2] battery_low_alarm; endproperty
	a_low: assert property (p_low) else $error("battery low not raised");
	property p_wrong; abs_mode && !motor_is_absolute |-> ##[1:2] wrong_motor_type_alarm; endproperty
	a_wrong: assert property (p_wrong) else $error("motor type not flagged");
	property p_latch;
		!$fell(battery_low_alarm) && !$fell(wrong_motor_type_alarm)
			&& !$fell(encoder_battery_loss_alarm);
	endproperty
	a_latch: assert property (p_latch) else $error("alarm dropped");
	property p_mode; started_q |=> $stable(abs_mode); endproperty
	a_mode: assert property (p_mode) else $error("mode changed while running");
	property p_invalid;
		$past(position_lost_alarm) && position_lost_alarm |-> !position_valid;
	endproperty
	a_invalid: assert property (p_invalid) else $error("lost position valid");
	property p_trip;
		$rose(overload_trip) |-> cnt_q + MS_TICKS + 3 >= lim && cnt_q <= lim + 3;
	endproperty
	a_trip: assert property (p_trip) else $error("overload trip time");
	c_err: cover property (reg_rvalid && reg_err);
	c_origin: cover property ($fell(position_lost_alarm));
	c_trip: cover property ($rose(overload_trip));
endmodule

bind absolute_position_tracker abs_pos_monitor #(.MS_TICKS(MS_TICKS)) u_mon (
	.clk, .reset, .motor_is_absolute, .battery_low, .battery_below_min, .coord_init_param_wr,
	.coord_init_param, .internal_position_program_mode, .origin_return_done, .load_over_300,
	.frame, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid, .reg_err, .abs_mode,
	.revolution_overflow_alarm, .wrong_motor_type_alarm, .battery_low_alarm,
	.encoder_battery_loss_alarm, .position_lost_alarm, .position_valid, .overload_trip
);

// file: tb/tb_top.sv
// Purpose: Self-checking bench of the absolute position tracker.
// Assumes: The millisecond tick is shortened to two clocks.
// Notes:   Origin is set at encoder zero, so the expected total is the travel itself.
`timescale 1ns/10ps
module tb_top;
	import abs_pos_pkg::*;
	localparam int TICKS = 2;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [16:0] enc_pulse = 17'h00000;
	logic        enc_valid = 1'b0;
	logic        motor_is_absolute = 1'b1;
	logic        absolute_system_enable_param = 1'b1;
	logic        backup_data_invalid = 1'b1;
	logic        origin_valid = 1'b0;
	logic        battery_low = 1'b0;
	logic        battery_below_min = 1'b0;
	logic        coord_init_param_wr = 1'b0;
	logic [15:0] coord_init_param = 16'h0000;
	logic        internal_position_program_mode = 1'b0;
	logic        origin_return_done = 1'b0;
	logic        load_over_300 = 1'b0;
	frame_t      frame = FRAME_SMALL;
	logic [15:0] gear_num = 16'h0003;
	logic [4:0]  gear_shift = 5'h01;
	logic [15:0] reg_addr, reg_rdata, d;
	logic [31:0] v;
	logic        reg_rd, reg_rvalid, reg_err, abs_mode, revolution_overflow_alarm, e;
	logic        wrong_motor_type_alarm, battery_low_alarm, encoder_battery_loss_alarm;
	logic        position_lost_alarm, position_valid, overload_trip;
	int          mismatches = 0;
	int          check_count = 0;
	int          pos = 0;

	always #2.5 clk = ~clk;

	absolute_position_tracker #(.MS_TICKS(TICKS)) dut (
		.clk, .reset, .enc_pulse, .enc_valid, .motor_is_absolute, .absolute_system_enable_param,
		.backup_data_invalid, .origin_valid, .battery_low, .battery_below_min, .coord_init_param_wr,
		.coord_init_param, .internal_position_program_mode, .origin_return_done, .load_over_300,
		.frame, .gear_num, .gear_shift, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid, .reg_err,
		.abs_mode, .revolution_overflow_alarm, .wrong_motor_type_alarm, .battery_low_alarm,
		.encoder_battery_loss_alarm, .position_lost_alarm, .position_valid, .overload_trip
	);
	host_reader host (.clk, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid, .reg_err);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Reset stands for a power cycle; stored settings are applied while it is held.
	task automatic power(input logic p, input logic m, input logic b);
		@(posedge clk);
		reset <= 1'b1;
		absolute_system_enable_param <= p;
		motor_is_absolute <= m;
		backup_data_invalid <= b;
		origin_valid <= ~b;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// Steps stay below a quarter turn so the turn count can follow.
	task automatic move_to(input int t);
		while (pos != t) begin
			if (t - pos > 16384)
				pos += 16384;
			else if (pos - t > 16384)
				pos -= 16384;
			else
				pos = t;
			@(posedge clk);
			enc_pulse <= pos[16:0];
			enc_valid <= 1'b1;
		end
		@(posedge clk);
		enc_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic coord(input logic [15:0] val);
		coord_init_param <= val;
		coord_init_param_wr <= 1'b1;
		@(posedge clk);
		coord_init_param_wr <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic overload(input frame_t f, input int lim);
		@(posedge clk);
		frame <= f;
		load_over_300 <= 1'b1;
		repeat (lim - 10) @(posedge clk);
		load_over_300 <= 1'b0;
		repeat (3) @(posedge clk);
		check(overload_trip, 1'b0);
		load_over_300 <= 1'b1;
		repeat (lim + 8) @(posedge clk);
		check(overload_trip, 1'b1);
		load_over_300 <= 1'b0;
	endtask

	initial begin
		power(1'b1, 1'b1, 1'b1);
		check(abs_mode, 1'b1);
		check(encoder_battery_loss_alarm, 1'b1);
		check(position_lost_alarm, 1'b1);
		check(wrong_motor_type_alarm, 1'b0);
		coord(16'h0002);
		check(position_lost_alarm, 1'b1);
		coord(COORD_INIT_VAL);
		check(position_lost_alarm, 1'b0);
		// The standing battery loss alarm keeps the position untrusted until a power cycle.
		check(position_valid, 1'b0);
		check(encoder_battery_loss_alarm, 1'b1);
		move_to(1360720);
		host.rd32(ADDR_BEFORE_GEAR, v);
		check(v, 32'h0014C350);
		host.rd32(ADDR_AFTER_GEAR, v);
		check(v, 32'h001F24F8);
		move_to(-5);
		host.rd32(ADDR_BEFORE_GEAR, v);
		check(v, 32'hFFFFFFFB);
		check(revolution_overflow_alarm, 1'b0);
		host.rd(16'h0002, d, e);
		check(e, 1'b1);
		check(d, 16'h0000);
		battery_low <= 1'b1;
		@(posedge clk);
		battery_low <= 1'b0;
		repeat (4) @(posedge clk);
		check(battery_low_alarm, 1'b1);
		battery_below_min <= 1'b1;
		@(posedge clk);
		battery_below_min <= 1'b0;
		repeat (4) @(posedge clk);
		check(position_lost_alarm, 1'b1);
		check(position_valid, 1'b0);
		internal_position_program_mode <= 1'b1;
		origin_return_done <= 1'b1;
		@(posedge clk);
		origin_return_done <= 1'b0;
		repeat (4) @(posedge clk);
		check(position_lost_alarm, 1'b0);
		host.rd32(ADDR_BEFORE_GEAR, v);
		check(v, 32'h00000000);
		overload(FRAME_SMALL, TRIP_SMALL_MS * TICKS);
		power(1'b1, 1'b1, 1'b0);
		check(encoder_battery_loss_alarm, 1'b0);
		check(position_lost_alarm, 1'b0);
		check(position_valid, 1'b1);
		overload(FRAME_80, TRIP_80_MS * TICKS);
		power(1'b0, 1'b0, 1'b0);
		absolute_system_enable_param <= 1'b1;
		repeat (4) @(posedge clk);
		check(abs_mode, 1'b0);
		check(wrong_motor_type_alarm, 1'b0);
		power(1'b1, 1'b0, 1'b0);
		check(wrong_motor_type_alarm, 1'b1);
		overload(FRAME_MID, TRIP_MID_MS * TICKS);
		finish_test;
	end

	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		finish_test;
	end
endmodule
